// file: smp_pkg.sv
`default_nettype none
// ---------------------------------------------------------------------
// shared constants of the synchronised pwm timer
// ---------------------------------------------------------------------
package smp_pkg;

    // bus and array sizes
    localparam int DW      = 16;
    localparam int AW      = 8;
    localparam int NCH     = 6;
    localparam int NCMP    = 16;
    localparam int NIOC    = 8;
    localparam int PRE_W   = 6;

    // register word addresses
    localparam logic [7:0] RUN_ADDR  = 8'h00; // run_control_reg
    localparam logic [7:0] SYNC_ADDR = 8'h01; // sync_select_reg
    localparam logic [7:0] CCR_BASE  = 8'h02; // counter_clock_ctrl_reg 0..5
    localparam logic [7:0] MDR_BASE  = 8'h08; // operating_mode_reg 0..5
    localparam logic [7:0] IOC_BASE  = 8'h0e; // pin_output_ctrl_reg 0..7
    localparam logic [7:0] CNT_BASE  = 8'h16; // channel_counter 0..5
    localparam logic [7:0] CMP_BASE  = 8'h1c; // compare_capture_value 0..15
    localparam logic [7:0] PIN_ADDR  = 8'h2c; // pin level status
    localparam logic [7:0] END_ADDR  = 8'h2d; // first unmapped word

    // counter clock control fields
    localparam int CKS_LSB = 0;               // 2-bit prescale select
    localparam int CLR_LSB = 2;               // 2-bit clear source
    localparam logic [1:0] CLR_NONE = 2'h0;
    localparam logic [1:0] CLR_A    = 2'h1;
    localparam logic [1:0] CLR_B    = 2'h2;
    localparam logic [1:0] CLR_SYNC = 2'h3;

    // operating mode fields
    localparam int MODE_LSB = 0;              // 2-bit mode
    localparam int BUFA_BIT = 2;              // third register buffers first
    localparam int BUFB_BIT = 3;              // fourth register buffers second
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_PWM2   = 2'h3;

    // pin output control: one 4-bit field per compare register
    localparam int IOF_W     = 4;
    localparam int IOF_INIT  = 0;             // level when stopped / cleared
    localparam int IOF_MATCH = 1;             // level on compare match
    localparam int IOF_CAP   = 2;             // input capture instead

    // reset values
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CMP_RST = 16'hffff;
    localparam logic [15:0] REG_RST = 16'h0000;

    // first compare index of a channel: 4,2,2,4,2,2 registers
    function automatic int cmp_base(input int ch);
        int b;
        b = 0;
        for (int c = 0; c < ch; c++) begin
            b = b + (((c == 0) || (c == 3)) ? 4 : 2);
        end
        return b;
    endfunction : cmp_base

    // channel that owns compare register i
    function automatic int cmp_chan(input int i);
        int ch;
        ch = 0;
        for (int c = 1; c < NCH; c++) begin
            if (i >= cmp_base(c)) begin
                ch = c;
            end
        end
        return ch;
    endfunction : cmp_chan

endpackage : smp_pkg
`default_nettype wire

// file: smp_timer.sv
`timescale 1ns/10ps
`default_nettype none
// Operation
// - run register starts or halts each of the six counters separately
// - stopped channel drives each non-capture, non-buffer pin with its selected initial level
// - in pwm mode 2 the initial level is taken when counter clears
// - buffering third/fourth register ignores its pin, reloads partner
// - six readable writable 16-bit counters, zeroed by reset or standby
// - counters are accessed as whole 16-bit words only
// - sixteen compare/capture registers, four on ch0 and ch3, two elsewhere
// - only ch0 and ch3 third and fourth registers may be buffers
// - compare/capture registers are accessed as whole 16-bit words only
// - eight pin output control registers, meaning depends on mode
// - sync register makes each counter independent or synchronised
// - pwm mode 2: one period register, others are duty registers
// - pwm mode 2: pin takes match level on its duty match
// - period match clear returns every pwm pin to initial level
// - duty equal to period leaves the pin unchanged on that match
// - six synchronised channels give up to fifteen pwm outputs
// - ch0 first compare match clears all synced counters, pwm mode 2 pins take their initial level
module smp_timer (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic [smp_pkg::AW-1:0]  addr_i,
    input  wire logic [smp_pkg::DW-1:0]  wdata_i,
    input  wire logic                    wr_stb_i,
    input  wire logic                    rd_stb_i,
    output var  logic [smp_pkg::DW-1:0]  rdata_o,
    input  wire logic                    standby_i,
    input  wire logic [smp_pkg::NCMP-1:0] tio_i,
    output var  logic [smp_pkg::NCMP-1:0] tio_o,
    output var  logic [smp_pkg::NCMP-1:0] tio_oe_o
);

    // -----------------------------------------------------------------
    // storage
    // -----------------------------------------------------------------
    logic [smp_pkg::NCH-1:0]   run;
    logic [smp_pkg::NCH-1:0]   sync;
    logic [3:0]                ccr   [smp_pkg::NCH];
    logic [3:0]                mdr   [smp_pkg::NCH];
    logic [15:0]               ioc   [smp_pkg::NIOC];
    logic [15:0]               cnt   [smp_pkg::NCH];
    logic [15:0]               cmp   [smp_pkg::NCMP];
    logic [smp_pkg::PRE_W-1:0] pre;
    logic [smp_pkg::NCMP-1:0]  tio_q;

    // per channel event wires
    logic [smp_pkg::NCH-1:0]   tick;
    logic [smp_pkg::NCH-1:0]   pwm;
    logic [smp_pkg::NCH-1:0]   own_clr;
    logic [smp_pkg::NCH-1:0]   clr;
    logic [smp_pkg::NCH-1:0]   own_per;
    logic [15:0]               per_val [smp_pkg::NCH];
    logic                      clr_sync;
    logic                      wr_sync;
    logic [smp_pkg::DW-1:0]    next_rdata;
    logic [7:0]                off_ccr;
    logic [7:0]                off_mdr;
    logic [7:0]                off_ioc;
    logic [7:0]                off_cnt;
    logic [7:0]                off_cmp;

    // -----------------------------------------------------------------
    // run and sync control registers
    // -----------------------------------------------------------------
    // run bits, one per counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run <= '0;
        end else if (wr_stb_i && addr_i == smp_pkg::RUN_ADDR) begin
            run <= wdata_i[smp_pkg::NCH-1:0];
        end
    end

    // synchronous operation select
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync <= '0;
        end else if (wr_stb_i && addr_i == smp_pkg::SYNC_ADDR) begin
            sync <= wdata_i[smp_pkg::NCH-1:0];
        end
    end

    // free running prescaler for the counter clock selects
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre <= '0;
        end else begin
            pre <= pre + 6'h01;
        end
    end

    // previous pin input level for capture edge detection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tio_q <= '0;
        end else begin
            tio_q <= tio_i;
        end
    end

    // one sync-clear source: any synced channel that clears itself
    assign clr_sync = |(own_clr & sync);

    // a counter write to any synced channel reaches all synced ones
    assign off_cnt = addr_i - smp_pkg::CNT_BASE;
    assign wr_sync = wr_stb_i && addr_i >= smp_pkg::CNT_BASE
                     && addr_i < smp_pkg::CMP_BASE
                     && sync[off_cnt[2:0]];

    // -----------------------------------------------------------------
    // channel counters
    // -----------------------------------------------------------------
    for (genvar k = 0; k < smp_pkg::NCH; k++) begin : g_ch
        localparam int B = smp_pkg::cmp_base(k);
        logic [1:0] cks;
        logic [1:0] csrc;
        logic       wr_hit;

        assign cks  = ccr[k][smp_pkg::CKS_LSB +: 2];
        assign csrc = ccr[k][smp_pkg::CLR_LSB +: 2];
        assign pwm[k] = mdr[k][smp_pkg::MODE_LSB +: 2]
                        == smp_pkg::MODE_PWM2;

        // counter tick from the selected prescale tap
        always_comb begin
            unique case (cks)
                2'h0: tick[k] = 1'b1;
                2'h1: tick[k] = pre[1:0] == 2'h0;
                2'h2: tick[k] = pre[3:0] == 4'h0;
                2'h3: tick[k] = pre[5:0] == 6'h00;
            endcase
        end

        // period register is the one picked as clear source
        assign per_val[k] = (csrc == smp_pkg::CLR_B) ? cmp[B + 1] : cmp[B];
        // only a channel that clears itself owns a period register;
        // a synced duty equal to the far period meets the clear instead
        assign own_per[k] = csrc == smp_pkg::CLR_A
                            || csrc == smp_pkg::CLR_B;

        // clear on match with the period register, checked on a tick
        assign own_clr[k] = run[k] && tick[k]
            && ((csrc == smp_pkg::CLR_A && cnt[k] == cmp[B])
             || (csrc == smp_pkg::CLR_B && cnt[k] == cmp[B + 1]));
        assign clr[k] = own_clr[k] || (sync[k] && clr_sync);

        assign wr_hit = wr_stb_i && (addr_i == smp_pkg::CNT_BASE + 8'(k)
                        || (sync[k] && wr_sync));

        // clock control register
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                ccr[k] <= '0;
            end else if (wr_stb_i && addr_i == smp_pkg::CCR_BASE + 8'(k)) begin
                ccr[k] <= wdata_i[3:0];
            end
        end

        // operating mode register; buffer bits only on ch0 and ch3
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                mdr[k] <= '0;
            end else if (wr_stb_i && addr_i == smp_pkg::MDR_BASE + 8'(k)) begin
                mdr[k] <= (k == 0 || k == 3) ? wdata_i[3:0]
                          : {2'h0, wdata_i[1:0]};
            end
        end

        // counter: standby, word write, clear, then count
        always_ff @(posedge clk_i) begin
            if (rst_i || standby_i) begin
                cnt[k] <= smp_pkg::CNT_RST;
            end else if (wr_hit) begin
                cnt[k] <= wdata_i;
            end else if (clr[k]) begin
                cnt[k] <= smp_pkg::CNT_RST;
            end else if (run[k] && tick[k]) begin
                cnt[k] <= cnt[k] + 16'h0001;
            end
        end
    end

    // -----------------------------------------------------------------
    // pin output control registers
    // -----------------------------------------------------------------
    for (genvar r = 0; r < smp_pkg::NIOC; r++) begin : g_ioc
        // two compare fields per register
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                ioc[r] <= smp_pkg::REG_RST;
            end else if (wr_stb_i && addr_i == smp_pkg::IOC_BASE + 8'(r)) begin
                ioc[r] <= wdata_i;
            end
        end
    end

    // -----------------------------------------------------------------
    // compare/capture registers and their pins
    // -----------------------------------------------------------------
    for (genvar i = 0; i < smp_pkg::NCMP; i++) begin : g_cmp
        localparam int CH  = smp_pkg::cmp_chan(i);
        localparam int SL  = i - smp_pkg::cmp_base(CH);
        localparam bit HB  = (CH == 0) || (CH == 3);
        localparam bit LOW = HB && (SL < 2);
        localparam bit HIG = HB && (SL >= 2);
        logic [3:0] fld;
        logic       cap;
        logic       bufd;
        logic       xfer;
        logic       match;
        logic       is_per;
        logic [1:0] csrc;

        assign fld  = ioc[i / 2][smp_pkg::IOF_W * (i % 2) +: 4];
        assign cap  = fld[smp_pkg::IOF_CAP];
        assign csrc = ccr[CH][smp_pkg::CLR_LSB +: 2];
        // this register acts as buffer for the one two below it
        assign bufd = HIG && mdr[CH][smp_pkg::BUFA_BIT + (SL % 2)];
        // partner buffer reloads this register on each clear
        assign xfer = LOW && clr[CH]
                      && mdr[CH][smp_pkg::BUFA_BIT + (SL % 2)];
        assign match = run[CH] && tick[CH] && cnt[CH] == cmp[i];
        assign is_per = pwm[CH]
            && ((csrc == smp_pkg::CLR_A && SL == 0)
             || (csrc == smp_pkg::CLR_B && SL == 1));

        // value: capture or buffer reload take over a bus write
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                cmp[i] <= smp_pkg::CMP_RST;
            end else if (cap && tio_i[i] && !tio_q[i]) begin
                cmp[i] <= cnt[CH];
            end else if (xfer) begin
                cmp[i] <= cmp[(i + 2) % smp_pkg::NCMP];
            end else if (wr_stb_i
                         && addr_i == smp_pkg::CMP_BASE + 8'(i)) begin
                cmp[i] <= wdata_i;
            end
        end

        // pin level
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                tio_o[i] <= 1'b0;
            end else if (cap || bufd) begin
                tio_o[i] <= 1'b0;
            end else if (!run[CH]) begin
                tio_o[i] <= fld[smp_pkg::IOF_INIT];
            end else if (pwm[CH]) begin
                if (clr[CH] || is_per) begin
                    tio_o[i] <= fld[smp_pkg::IOF_INIT];
                end else if (match && !(own_per[CH]
                             && cmp[i] == per_val[CH])) begin
                    tio_o[i] <= fld[smp_pkg::IOF_MATCH];
                end
            end else if (match) begin
                tio_o[i] <= fld[smp_pkg::IOF_MATCH];
            end
        end

        // pin drive enable: off for capture and for buffers
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                tio_oe_o[i] <= 1'b0;
            end else begin
                tio_oe_o[i] <= !(cap || bufd);
            end
        end
    end

    // -----------------------------------------------------------------
    // register read
    // -----------------------------------------------------------------
    assign off_ccr = addr_i - smp_pkg::CCR_BASE;
    assign off_mdr = addr_i - smp_pkg::MDR_BASE;
    assign off_ioc = addr_i - smp_pkg::IOC_BASE;
    assign off_cmp = addr_i - smp_pkg::CMP_BASE;

    // read multiplexer, unmapped words read zero
    always_comb begin
        next_rdata = '0;
        if (addr_i == smp_pkg::RUN_ADDR) begin
            next_rdata = {10'h000, run};
        end else if (addr_i == smp_pkg::SYNC_ADDR) begin
            next_rdata = {10'h000, sync};
        end else if (addr_i < smp_pkg::MDR_BASE) begin
            next_rdata = {12'h000, ccr[off_ccr[2:0]]};
        end else if (addr_i < smp_pkg::IOC_BASE) begin
            next_rdata = {12'h000, mdr[off_mdr[2:0]]};
        end else if (addr_i < smp_pkg::CNT_BASE) begin
            next_rdata = ioc[off_ioc[2:0]];
        end else if (addr_i < smp_pkg::CMP_BASE) begin
            next_rdata = cnt[off_cnt[2:0]];
        end else if (addr_i < smp_pkg::PIN_ADDR) begin
            next_rdata = cmp[off_cmp[3:0]];
        end else if (addr_i < smp_pkg::END_ADDR) begin
            next_rdata = tio_o;
        end
    end

    // read data stand one cycle after the strobe only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= rd_stb_i ? next_rdata : '0;
        end
    end

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // ch0 second compare hit on a tick
    logic match1;
    assign match1 = tick[0] && cnt[0] == cmp[1];

    sequence s_run_read;
        rd_stb_i && addr_i == smp_pkg::RUN_ADDR;
    endsequence

    sequence s_ch0_duty;
        run[0] && pwm[0] && !clr[0] && !ioc[0][6] && match1
        && cmp[1] != per_val[0] && ccr[0][3:2] != smp_pkg::CLR_B;
    endsequence

    a_run_readback: assert property (
        s_run_read |=> rdata_o == {10'h000, $past(run)})
        else $error("run register read back wrong");

    a_stopped_hold: assert property (
        !run[1] && !standby_i && !wr_stb_i && !clr[1]
        |=> cnt[1] == $past(cnt[1]))
        else $error("stopped counter moved");

    a_stop_init_level: assert property (
        !run[0] && !ioc[0][6] |=> tio_o[1] == $past(ioc[0][4]))
        else $error("stopped pin not at initial level");

    a_count_step: assert property (
        run[0] && tick[0] && !clr[0] && !standby_i && !wr_stb_i
        |=> cnt[0] == $past(cnt[0]) + 16'h0001)
        else $error("counter did not step by one");

    a_standby_zero: assert property (
        standby_i |=> cnt[0] == 16'h0000 && cnt[5] == 16'h0000)
        else $error("standby did not zero counters");

    a_word_write: assert property (
        wr_stb_i && addr_i == smp_pkg::CNT_BASE && !standby_i
        |=> cnt[0] == $past(wdata_i))
        else $error("counter word write lost");

    a_sync_clear: assert property (
        own_clr[0] && sync[0] && sync[5] && !wr_stb_i && !standby_i
        |=> cnt[5] == 16'h0000)
        else $error("synced counter not cleared");

    a_clear_init: assert property (
        clr[0] && run[0] && pwm[0] && !ioc[0][6]
        |=> tio_o[1] == $past(ioc[0][4]))
        else $error("pin not back to initial level on clear");

    a_duty_level: assert property (
        s_ch0_duty |=> tio_o[1] == $past(ioc[0][5]))
        else $error("duty match level not taken");

    a_buffer_load: assert property (
        clr[0] && mdr[0][smp_pkg::BUFA_BIT] && !ioc[0][2]
        |=> cmp[0] == $past(cmp[2]))
        else $error("buffer not transferred on clear");

endmodule : smp_timer
`default_nettype wire

// file: smp_pwm_load.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------
// pin load: pulled-down lines and high-time meters
// ---------------------------------------------------------
module smp_pwm_load (
    input  wire logic                               clk_i,
    input  wire logic                               meas_i,
    input  wire logic [smp_pkg::NCMP-1:0]           pin_i,
    input  wire logic [smp_pkg::NCMP-1:0]           pin_oe_i,
    input  wire logic [smp_pkg::NCMP-1:0]           drv_i,
    output var  logic [smp_pkg::NCMP-1:0]           line_o,
    output var  logic [smp_pkg::NCMP-1:0][15:0]     hi_cnt_o
);
    // a released line sinks to its pull-down unless the far side drives it
    always_comb begin
        for (int i = 0; i < smp_pkg::NCMP; i++) begin
            line_o[i] = pin_oe_i[i] ? pin_i[i] : drv_i[i];
        end
    end
    // count high cycles of each line while a measurement is open
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < smp_pkg::NCMP; i++) begin
            if (!meas_i) begin
                hi_cnt_o[i] <= 16'h0000;
            end else if (line_o[i]) begin
                hi_cnt_o[i] <= hi_cnt_o[i] + 16'h0001;
            end
        end
    end
endmodule : smp_pwm_load
`default_nettype wire

// file: sync_multichannel_pwm_timer_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("[FAIL] %0t got %h want %h", $time, (got), (exp)); \
    end \
end
module sync_multichannel_pwm_timer_bench;
    localparam int P = 40; // period compare value; pwm period is P+1 ticks
    localparam int K = 3;  // periods per measurement
    // ---------------------------------------------------------
    // signals
    // ---------------------------------------------------------
    logic              clk     = 1'b0;
    logic              rst     = 1'b1;
    logic [7:0]        addr    = 8'h00;
    logic [15:0]       wdata   = 16'h0000;
    logic              wr_stb  = 1'b0;
    logic              rd_stb  = 1'b0;
    logic              standby = 1'b0;
    logic              meas    = 1'b0;
    logic [15:0]       ext     = 16'h0000;
    logic              rd_pend = 1'b0;
    logic [15:0]       rdata;
    logic [15:0]       tio_in;
    logic [15:0]       tio_out;
    logic [15:0]       tio_oe;
    logic [15:0][15:0] hi_cnt;
    logic [15:0]       exp_q[$];
    logic [15:0]       e_now;
    logic [15:0]       duty[16];
    logic [31:0]       seed;
    int                error_cnt = 0;
    int                n_tests   = 0;
    int                cyc       = 0;
    int                w;
    // ---------------------------------------------------------
    // design and pin load
    // ---------------------------------------------------------
    smp_timer dut_u (
        .clk_i    (clk),
        .rst_i    (rst),
        .addr_i   (addr),
        .wdata_i  (wdata),
        .wr_stb_i (wr_stb),
        .rd_stb_i (rd_stb),
        .rdata_o  (rdata),
        .standby_i(standby),
        .tio_i    (tio_in),
        .tio_o    (tio_out),
        .tio_oe_o (tio_oe)
    );
    smp_pwm_load load_u (
        .clk_i   (clk),
        .meas_i  (meas),
        .pin_i   (tio_out),
        .pin_oe_i(tio_oe),
        .drv_i   (ext),
        .line_o  (tio_in),
        .hi_cnt_o(hi_cnt)
    );
    // 20 MHz clock
    always #25 clk = ~clk;
    // ---------------------------------------------------------
    // bus tasks, verdict, random source
    // ---------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        rd_stb <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        addr   <= a;
        rd_stb <= 1'b1;
        wr_stb <= 1'b0;
        exp_q.push_back(e);
    endtask : rd
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            wr_stb <= 1'b0;
            rd_stb <= 1'b0;
        end
    endtask : idle
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : xs
    // read data checked in the cycle after its strobe
    always @(posedge clk) begin
        if (rd_pend && exp_q.size() > 0) begin
            e_now = exp_q.pop_front();
            `CHK(rdata, e_now)
        end
        rd_pend <= rd_stb;
    end
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            test_done();
        end
    end
    // ---------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(smp_pkg::RUN_ADDR, 16'h0000);
        for (int c = 0; c < 6; c++) begin
            rd(smp_pkg::CNT_BASE + 8'(c), 16'h0000);
        end
        for (int i = 0; i < 16; i++) begin
            rd(smp_pkg::CMP_BASE + 8'(i), smp_pkg::CMP_RST);
        end
        wr(smp_pkg::RUN_ADDR, 16'hffc0);
        rd(smp_pkg::RUN_ADDR, 16'h0000);
        wr(smp_pkg::END_ADDR, 16'h5a5a);
        rd(smp_pkg::END_ADDR, 16'h0000);
        wr(smp_pkg::MDR_BASE + 8'h01, 16'h000f);
        wr(smp_pkg::MDR_BASE + 8'h03, 16'h000f);
        rd(smp_pkg::MDR_BASE + 8'h01, 16'h0003);
        rd(smp_pkg::MDR_BASE + 8'h03, 16'h000f);
        wr(smp_pkg::IOC_BASE, 16'h0011);
        idle(1);
        rd(smp_pkg::PIN_ADDR, 16'h0003);
        // one channel runs one tick while its neighbour holds
        wr(smp_pkg::CNT_BASE, 16'h1234);
        wr(smp_pkg::RUN_ADDR, 16'h0002);
        wr(smp_pkg::RUN_ADDR, 16'h0000);
        rd(smp_pkg::CNT_BASE, 16'h1234);
        rd(smp_pkg::CNT_BASE + 8'h01, 16'h0001);
        wr(smp_pkg::CNT_BASE + 8'h02, 16'hbeef);
        idle(1);
        standby <= 1'b1;
        idle(1);
        standby <= 1'b0;
        rd(smp_pkg::CNT_BASE + 8'h02, 16'h0000);
        // ch2 first compare captures when the far side raises its line
        wr(smp_pkg::IOC_BASE + 8'h03, 16'h0004);
        wr(smp_pkg::RUN_ADDR, 16'h0004);
        idle(3);
        ext[6] <= 1'b1;
        wr(smp_pkg::RUN_ADDR, 16'h0000);
        rd(smp_pkg::CMP_BASE + 8'h06, 16'h0002);
        // synchronised pwm mode 2, set up while all counters stand
        for (int c = 0; c < 6; c++) begin
            wr(smp_pkg::CNT_BASE + 8'(c), 16'h0000);
            wr(smp_pkg::CCR_BASE + 8'(c), (c == 0) ? 16'h4 : 16'hc);
            wr(smp_pkg::MDR_BASE + 8'(c),
               (c == 0) ? 16'h0007 : 16'h0003);
        end
        wr(smp_pkg::SYNC_ADDR, 16'hffff);
        rd(smp_pkg::SYNC_ADDR, 16'h003f);
        for (int r = 0; r < 8; r++) begin
            wr(smp_pkg::IOC_BASE + 8'(r), 16'h0022);
        end
        seed = 32'h00012520; // start value 75040
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            duty[i] = 16'(1 + seed % (P - 1));
        end
        duty[0] = 16'(2 * P); // first period only, then reloaded
        duty[2] = 16'(P);
        duty[5] = 16'(P);
        duty[15] = 16'h0001;
        for (int i = 0; i < 16; i++) begin
            wr(smp_pkg::CMP_BASE + 8'(i), duty[i]);
        end
        wr(smp_pkg::RUN_ADDR, 16'h003f);
        idle(3 * (P + 1));
        meas <= 1'b1;
        idle(K * (P + 1));
        meas <= 1'b0;
        #1;
        for (int i = 0; i < 16; i++) begin
            w = (duty[i] >= 16'(P)) ? 0 : K * (P - int'(duty[i]));
            `CHK(hi_cnt[i], 16'(w))
        end
        wr(smp_pkg::RUN_ADDR, 16'h0000);
        idle(1);
        rd(smp_pkg::PIN_ADDR, 16'h0000);
        idle(3);
        test_done();
    end
endmodule : sync_multichannel_pwm_timer_bench
`default_nettype wire
